/* core/dual_gpio_port_overrides.sv */
// Functional notes
// - two ports, eight pins, direction and latch
// - direction 0 drives latch, 1 reads pin
// - analog select keeps first port output driving
// - first port pins 4-7 read zero when analog
// - reset selects analog on all first pins
// - lcd segment overrides every other pin function
// - first pins 0-3 carry bus address 16-19
// - bus enabled forces second port control outputs
// - second pins carry strobes in fixed order
// - pad config bit 2 gates all pull-ups
// - pull-up off while pin is an output
// - reset leaves second port pull-ups off
// - reset makes second port pins inputs
// - overrides never written into direction register
`timescale 1ns/1ps
module dual_gpio_port_overrides
   import gpio_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // register writes
   input wire logic [7:0] wr_data,
   input wire logic first_latch_wr,
   input wire logic first_port_wr,
   input wire logic first_dir_wr,
   input wire logic second_latch_wr,
   input wire logic second_port_wr,
   input wire logic second_dir_wr,
   input wire logic analog_low_wr,
   input wire logic analog_high_wr,
   input wire logic mem_ctrl_wr,
   input wire logic pad_cfg_wr,
   // register reads
   output logic [7:0] first_port_pin_read,
   output logic [7:0] first_port_output_latch,
   output logic [7:0] first_port_direction,
   output logic [7:0] second_port_pin_read,
   output logic [7:0] second_port_output_latch,
   output logic [7:0] second_port_direction,
   output logic [7:0] analog_select_low,
   output logic [7:0] analog_select_high,
   output logic [7:0] memory_control_register,
   output logic [7:0] pad_configuration_register,
   // lcd controller
   input wire logic [7:0] lcd_sel_first,
   input wire logic [7:0] lcd_segment_output_first,
   input wire logic [7:0] lcd_sel_second,
   input wire logic [7:0] lcd_segment_output_second,
   // external memory interface
   input wire logic mem_addr_used,
   input wire logic [3:0] mem_addr_upper,
   input wire mem_ctrl_t mem_ctrl,
   output logic mem_bus_active,
   // first port pads
   input wire logic [7:0] first_pin_in,
   output logic [7:0] first_pin_out,
   output logic [7:0] first_pin_oe,
   output logic [7:0] first_analog_en,
   // second port pads
   input wire logic [7:0] second_pin_in,
   output logic [7:0] second_pin_out,
   output logic [7:0] second_pin_oe,
   output logic [7:0] second_port_pullup_enable
);

   // software-visible state
   port_regs_t first_q, first_d;
   port_regs_t second_q, second_d;
   logic [7:0] ana_lo_q, ana_lo_d;
   logic [7:0] ana_hi_q, ana_hi_d;
   logic [7:0] memcfg_q, memcfg_d;
   logic [7:0] pad_configuration_register_q, pad_configuration_register_d;

   // pin synchronisers
   logic [7:0] first_s1_q, first_s2_q;
   logic [7:0] second_s1_q, second_s2_q;

   // registered pad and read state
   pad_drive_t first_pad_q, first_pad_d;
   pad_drive_t second_pad_q, second_pad_d;
   logic [7:0] first_rd_q, first_rd_d;
   logic [7:0] second_rd_q, second_rd_d;
   logic [7:0] ana_en_q, ana_en_d;
   logic [7:0] pullup_q, pullup_d;
   logic bus_q, bus_d;

   // decoded override terms
   logic bus_on;
   logic [7:0] first_ana_sel;
   logic [7:0] first_alt_sel;
   logic [7:0] first_alt_val;
   logic [7:0] first_gate;
   logic [7:0] second_ana_sel;
   logic [7:0] second_din;

   // clearing the disable bit turns the memory bus on
   assign bus_on = ~memcfg_q[MEM_BUS_DIS_BIT];
   assign first_ana_sel = {ana_hi_q[3:0], ana_lo_q[3:0]};
   assign second_ana_sel = ALL_OFF;

   // address pins take priority over direction bits
   always_comb begin
      first_alt_sel = ALL_OFF;
      first_alt_val = ALL_OFF;
      first_gate = ALL_OFF;
      for (int i = 0; i < ADDR_PINS; i++) begin
         first_alt_sel[i] = bus_on & mem_addr_used;
         first_alt_val[i] = mem_addr_upper[i];
      end
      for (int i = GATED_PIN_LO; i < PORT_W; i++) begin
         first_gate[i] = 1'b1;
      end
   end

   // register writes; no override ever reaches dir
   always_comb begin
      first_d = first_q;
      second_d = second_q;
      ana_lo_d = ana_lo_q;
      ana_hi_d = ana_hi_q;
      memcfg_d = memcfg_q;
      pad_configuration_register_d = pad_configuration_register_q;
      if (first_latch_wr || first_port_wr) begin
         first_d.latch = wr_data;
      end
      if (second_latch_wr || second_port_wr) begin
         second_d.latch = wr_data;
      end
      if (first_dir_wr) begin
         first_d.dir = wr_data;
      end
      if (second_dir_wr) begin
         second_d.dir = wr_data;
      end
      if (analog_low_wr) begin
         ana_lo_d = wr_data;
      end
      if (analog_high_wr) begin
         ana_hi_d = wr_data;
      end
      if (mem_ctrl_wr) begin
         memcfg_d = wr_data;
      end
      if (pad_cfg_wr) begin
         pad_configuration_register_d = wr_data;
      end
   end

   // register state, reset to inputs, analog, pull-ups off
   always_ff @(posedge clk) begin
      if (rst) begin
         first_q <= '{dir: DIR_RESET, latch: LATCH_RESET};
         second_q <= '{dir: DIR_RESET, latch: LATCH_RESET};
         ana_lo_q <= ANALOG_RESET;
         ana_hi_q <= ANALOG_RESET;
         memcfg_q <= MEM_CTRL_RESET;
         pad_configuration_register_q <= PAD_CFG_RESET;
      end else begin
         first_q <= first_d;
         second_q <= second_d;
         ana_lo_q <= ana_lo_d;
         ana_hi_q <= ana_hi_d;
         memcfg_q <= memcfg_d;
         pad_configuration_register_q <= pad_configuration_register_d;
      end
   end

   // two-stage pin synchronisers
   always_ff @(posedge clk) begin
      if (rst) begin
         first_s1_q <= ALL_OFF;
         first_s2_q <= ALL_OFF;
         second_s1_q <= ALL_OFF;
         second_s2_q <= ALL_OFF;
      end else begin
         first_s1_q <= first_pin_in;
         first_s2_q <= first_s1_q;
         second_s1_q <= second_pin_in;
         second_s2_q <= second_s1_q;
      end
   end

   // one slice per pin on each port
   for (genvar i = 0; i < PORT_W; i++) begin : g_first
      pin_slice u_pin (
         .dir(first_q.dir[i]),
         .latch(first_q.latch[i]),
         .lcd_sel(lcd_sel_first[i]),
         .lcd_val(lcd_segment_output_first[i]),
         .alt_sel(first_alt_sel[i]),
         .alt_val(first_alt_val[i]),
         .analog_sel(first_ana_sel[i]),
         .gate_in(first_gate[i]),
         .pin_lvl(first_s2_q[i]),
         .out(first_pad_d.out[i]),
         .oe(first_pad_d.oe[i]),
         .din(first_rd_d[i]),
         .analog_en(ana_en_d[i])
      );
   end

   for (genvar i = 0; i < PORT_W; i++) begin : g_second
      pin_slice u_pin (
         .dir(second_q.dir[i]),
         .latch(second_q.latch[i]),
         .lcd_sel(lcd_sel_second[i]),
         .lcd_val(lcd_segment_output_second[i]),
         .alt_sel(bus_on),
         .alt_val(mem_ctrl[i]),
         .analog_sel(second_ana_sel[i]),
         .gate_in(1'b0),
         .pin_lvl(second_s2_q[i]),
         .out(second_pad_d.out[i]),
         .oe(second_pad_d.oe[i]),
         .din(second_din[i]),
         .analog_en()
      );
   end

   // pull-ups: global enable, off on any driven pin
   always_comb begin
      second_rd_d = second_din;
      bus_d = bus_on;
      pullup_d = ALL_OFF;
      if (pad_configuration_register_q[PULLUP_EN_BIT]) begin
         pullup_d = ~second_pad_d.oe;
      end
   end

   // registered pad drive and read values
   always_ff @(posedge clk) begin
      if (rst) begin
         first_pad_q <= '{out: ALL_OFF, oe: ALL_OFF};
         second_pad_q <= '{out: ALL_OFF, oe: ALL_OFF};
         first_rd_q <= ALL_OFF;
         second_rd_q <= ALL_OFF;
         ana_en_q <= ALL_OFF;
         pullup_q <= ALL_OFF;
         bus_q <= 1'b0;
      end else begin
         first_pad_q <= first_pad_d;
         second_pad_q <= second_pad_d;
         first_rd_q <= first_rd_d;
         second_rd_q <= second_rd_d;
         ana_en_q <= ana_en_d;
         pullup_q <= pullup_d;
         bus_q <= bus_d;
      end
   end

   // outputs straight from flip-flops
   assign first_port_pin_read = first_rd_q;
   assign first_port_output_latch = first_q.latch;
   assign first_port_direction = first_q.dir;
   assign second_port_pin_read = second_rd_q;
   assign second_port_output_latch = second_q.latch;
   assign second_port_direction = second_q.dir;
   assign analog_select_low = ana_lo_q;
   assign analog_select_high = ana_hi_q;
   assign memory_control_register = memcfg_q;
   assign pad_configuration_register = pad_configuration_register_q;
   assign mem_bus_active = bus_q;
   assign first_pin_out = first_pad_q.out;
   assign first_pin_oe = first_pad_q.oe;
   assign first_analog_en = ana_en_q;
   assign second_pin_out = second_pad_q.out;
   assign second_pin_oe = second_pad_q.oe;
   assign second_port_pullup_enable = pullup_q;

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   logic [7:0] first_norm;
   assign first_norm = ~(lcd_sel_first | first_alt_sel);

   sequence s_latch_wr;
      (first_latch_wr || first_port_wr) && !rst;
   endsequence

   sequence s_bus_drive;
      bus_on && (lcd_sel_second == ALL_OFF);
   endsequence

   chk_dir_sets_oe: assert property (
      1 |=> ((first_pad_q.oe ^ ~$past(first_q.dir)) & $past(first_norm))
         == ALL_OFF)
      else $error("first port enable does not follow direction");

   chk_analog_keeps_out: assert property (
      1 |=> ((first_pad_q.out ^ $past(first_q.latch)) & $past(first_norm))
         == ALL_OFF)
      else $error("first port output lost its latch value");

   chk_analog_gates_in: assert property (
      1 |=> (first_rd_q[7:4] & $past(first_ana_sel[7:4]) &
         ~$past(first_alt_sel[7:4])) == 4'h0)
      else $error("analog pin read returned pin level");

   chk_lcd_owns_pin: assert property (
      1 |=> ((first_pad_q.oe & $past(lcd_sel_first)) == $past(lcd_sel_first))
         && (((first_pad_q.out ^ $past(lcd_segment_output_first)) &
         $past(lcd_sel_first)) == ALL_OFF)
         && ((first_rd_q & $past(lcd_sel_first)) == ALL_OFF))
      else $error("segment function did not own the pin");

   chk_addr_override: assert property (
      bus_on && mem_addr_used && (lcd_sel_first[3:0] == 4'h0)
         |=> first_pad_q.out[3:0] == $past(mem_addr_upper)
         && first_pad_q.oe[3:0] == 4'hF)
      else $error("address bits not driven on first port");

   chk_bus_ctrl_out: assert property (
      s_bus_drive |=> second_pad_q.oe == ALL_ON
         && second_pad_q.out == $past(mem_ctrl))
      else $error("memory strobes not driven on second port");

   chk_pullup_global: assert property (
      !pad_configuration_register_q[PULLUP_EN_BIT] |=> pullup_q == ALL_OFF)
      else $error("pull-up on while globally disabled");

   chk_pullup_off_out: assert property (
      (pullup_q & second_pad_q.oe) == ALL_OFF)
      else $error("pull-up on for a driven pin");

   chk_reset_state: assert property (
      $past(rst) |-> pullup_q == ALL_OFF && second_pad_q.oe == ALL_OFF
         && second_q.dir == DIR_RESET && first_ana_sel == ALL_ON)
      else $error("state after reset is wrong");

   chk_dir_not_forced: assert property (
      !first_dir_wr && !second_dir_wr |=> first_q.dir == $past(first_q.dir)
         && second_q.dir == $past(second_q.dir))
      else $error("direction register changed without a write");

   chk_latch_write: assert property (
      s_latch_wr |=> first_q.latch == $past(wr_data) ##1
         first_pad_q.out[7:4] == $past(first_q.latch[7:4]) ||
         lcd_sel_first[7:4] != 4'h0 || $past(lcd_sel_first[7:4]) != 4'h0)
      else $error("latch write not loaded or not driven");

endmodule : dual_gpio_port_overrides

/* core/gpio_pkg.sv */
package gpio_pkg;

   // port geometry
   localparam int PORT_W = 8;
   localparam int ADDR_PINS = 4;
   localparam int ADDR_LSB = 16;
   localparam int GATED_PIN_LO = 4;

   // control bit positions
   localparam int MEM_BUS_DIS_BIT = 7;
   localparam int PULLUP_EN_BIT = 2;

   // reset values
   localparam logic [7:0] DIR_RESET = 8'hFF;
   localparam logic [7:0] LATCH_RESET = 8'h00;
   localparam logic [7:0] ANALOG_RESET = 8'hFF;
   localparam logic [7:0] MEM_CTRL_RESET = 8'h80;
   localparam logic [7:0] PAD_CFG_RESET = 8'h00;
   localparam logic [7:0] ALL_OFF = 8'h00;
   localparam logic [7:0] ALL_ON = 8'hFF;

   // direction and latch of one port
   typedef struct packed {
      logic [7:0] dir;
      logic [7:0] latch;
   } port_regs_t;

   // drive state of one port's pads
   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
   } pad_drive_t;

   // memory interface control strobes, bit 7 first
   typedef struct packed {
      logic upper_byte_select;
      logic lower_byte_select;
      logic chip_enable;
      logic byte_access_zero;
      logic write_high_strobe;
      logic write_low_strobe;
      logic output_enable;
      logic address_latch_enable;
   } mem_ctrl_t;

endpackage : gpio_pkg

/* core/pin_slice.sv */
`timescale 1ns/1ps
module pin_slice (
   // normal port control
   input wire logic dir,
   input wire logic latch,
   // overriding functions
   input wire logic lcd_sel,
   input wire logic lcd_val,
   input wire logic alt_sel,
   input wire logic alt_val,
   input wire logic analog_sel,
   input wire logic gate_in,
   // synchronised pin level
   input wire logic pin_lvl,
   // pad results
   output logic out,
   output logic oe,
   output logic din,
   output logic analog_en
);

   // function priority: segment, bus, analog, then normal
   always_comb begin
      out = latch;
      oe = 1'b0;
      din = pin_lvl;
      analog_en = 1'b0;
      if (lcd_sel) begin
         out = lcd_val;
         oe = 1'b1;
         din = 1'b0;
      end else if (alt_sel) begin
         out = alt_val;
         oe = 1'b1;
      end else begin
         // analog select never touches the output driver
         out = latch;
         oe = ~dir;
         analog_en = analog_sel;
         din = (analog_sel & gate_in) ? 1'b0 : pin_lvl;
      end
   end

endmodule : pin_slice

/* tb/pad_model.sv */
`timescale 1ns/1ps
module pad_model (
   // clock
   input wire logic clk,
   // what the port drives
   input wire logic [7:0] out,
   input wire logic [7:0] oe,
   input wire logic [7:0] pu,
   // outside driver
   input wire logic [7:0] ext_val,
   input wire logic [7:0] ext_en,
   // resolved pad level
   output logic [7:0] lvl
);
   logic [7:0] float_q;

   // a floating pad wanders, so it never keeps a stale level;
   // seeded once here, then toggled by the one process below
   initial float_q = 8'h5A;
   always @(posedge clk) begin
      float_q <= ~float_q;
   end

   // port drive wins, then outside driver, then pull-up
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (oe[i]) lvl[i] = out[i];
         else if (ext_en[i]) lvl[i] = ext_val[i];
         else if (pu[i]) lvl[i] = 1'b1;
         else lvl[i] = float_q[i];
      end
   end
endmodule : pad_model

/* tb/testbench.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
$display("[ERR] %s exp %h got %h", n, e, g); num_errors++; end end
module testbench;
   import gpio_pkg::*;
   logic clk, rst;
   logic [7:0] wr_data;
   logic [9:0] wstb;
   logic [7:0] lcd_s1, lcd_v1, lcd_s2, lcd_v2, ext1, en1;
   logic mem_addr_used;
   logic [3:0] mem_addr_upper;
   mem_ctrl_t mc;
   logic mem_bus_active;
   logic [7:0] rd1, lat1, dir1, rd2, lat2, dir2, anl, anh, memr, padr;
   logic [7:0] in1, out1, oe1, aen1, in2, out2, oe2, pu2;
   int num_errors = 0;
   int samples_checked = 0;
   int cycles = 0;

   // write strobe indices
   localparam int FLAT = 0, FPRT = 1, FDIR = 2, SLAT = 3, SPRT = 4;
   localparam int SDIR = 5, ANL = 6, ANH = 7, MEM = 8, PAD = 9;

   dual_gpio_port_overrides dut (.clk(clk), .rst(rst),
      .wr_data(wr_data), .first_latch_wr(wstb[0]),
      .first_port_wr(wstb[1]), .first_dir_wr(wstb[2]),
      .second_latch_wr(wstb[3]), .second_port_wr(wstb[4]),
      .second_dir_wr(wstb[5]), .analog_low_wr(wstb[6]),
      .analog_high_wr(wstb[7]), .mem_ctrl_wr(wstb[8]),
      .pad_cfg_wr(wstb[9]), .first_port_pin_read(rd1),
      .first_port_output_latch(lat1), .first_port_direction(dir1),
      .second_port_pin_read(rd2), .second_port_output_latch(lat2),
      .second_port_direction(dir2), .analog_select_low(anl),
      .analog_select_high(anh), .memory_control_register(memr),
      .pad_configuration_register(padr), .lcd_sel_first(lcd_s1),
      .lcd_segment_output_first(lcd_v1), .lcd_sel_second(lcd_s2),
      .lcd_segment_output_second(lcd_v2),
      .mem_addr_used(mem_addr_used), .mem_addr_upper(mem_addr_upper),
      .mem_ctrl(mc), .mem_bus_active(mem_bus_active),
      .first_pin_in(in1), .first_pin_out(out1), .first_pin_oe(oe1),
      .first_analog_en(aen1), .second_pin_in(in2),
      .second_pin_out(out2), .second_pin_oe(oe2),
      .second_port_pullup_enable(pu2));

   // first port has no pull-ups; second port is left undriven outside
   pad_model pads1 (.clk(clk), .out(out1), .oe(oe1), .pu(8'h00),
      .ext_val(ext1), .ext_en(en1), .lvl(in1));
   pad_model pads2 (.clk(clk), .out(out2), .oe(oe2), .pu(pu2),
      .ext_val(8'h00), .ext_en(8'h00), .lvl(in2));

   // 40 MHz clock
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   // hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         num_errors++;
         give_verdict();
      end
   end

   task automatic give_verdict();
      if (num_errors == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : give_verdict

   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask : step

   // one write pulse, then one edge so pads have settled
   task automatic wr(input int idx, input logic [7:0] d);
      wstb[idx] = 1'b1;
      wr_data = d;
      step(1);
      wstb[idx] = 1'b0;
      step(1);
   endtask : wr

   task automatic chk_reset();
      `CHK("dir1", 8'hFF, dir1)
      `CHK("dir2", 8'hFF, dir2)
      `CHK("oe2", 8'h00, oe2)
      `CHK("pu2", 8'h00, pu2)
      `CHK("lat2", 8'h00, lat2)
      `CHK("anl", 8'hFF, anl)
      `CHK("anh", 8'hFF, anh)
      `CHK("memr", 8'h80, memr)
      `CHK("padr", 8'h00, padr)
   endtask : chk_reset

   // main sequence
   initial begin
      rst = 1'b1; wr_data = 8'h00; wstb = '0;
      lcd_s1 = 8'h00; lcd_v1 = 8'h00; lcd_s2 = 8'h00; lcd_v2 = 8'h00;
      ext1 = 8'h3C; en1 = 8'hFF;
      mem_addr_used = 1'b0; mem_addr_upper = 4'h0; mc = '0;
      step(3);
      rst = 1'b0;
      step(2);
      chk_reset();
      `CHK("aen1", 8'hFF, aen1)
      `CHK("oe1", 8'h00, oe1)
      `CHK("bus", 1'b0, mem_bus_active)
      // first port output while analog stays selected
      wr(FDIR, 8'h00);
      wr(FPRT, 8'hA5);
      `CHK("lat1", 8'hA5, lat1)
      `CHK("oe1", 8'hFF, oe1)
      `CHK("out1", 8'hA5, out1)
      step(3);
      `CHK("rd1", 8'h05, rd1)
      wr(FLAT, 8'h00);
      `CHK("out1", 8'h00, out1)
      // input path and analog gating of upper pins
      wr(FDIR, 8'hFF);
      step(3);
      `CHK("rd1", 8'h0C, rd1)
      wr(ANH, 8'h00);
      step(2);
      `CHK("rd1", 8'h3C, rd1)
      `CHK("aen1", 8'h0F, aen1)
      wr(ANL, 8'h00);
      `CHK("aen1", 8'h00, aen1)
      // lcd takes pins 0 and 7
      ext1 = 8'hFF;
      lcd_s1 = 8'h81;
      lcd_v1 = 8'h01;
      step(4);
      `CHK("oe1", 8'h81, oe1)
      `CHK("out1", 8'h01, out1 & 8'h81)
      `CHK("rd1", 8'h7E, rd1)
      `CHK("dir1", 8'hFF, dir1)
      // memory bus on, address on first pins 0-3 under lcd
      mem_addr_used = 1'b1;
      mem_addr_upper = 4'hA;
      lcd_s2 = 8'h80;
      wr(MEM, 8'h00);
      `CHK("bus", 1'b1, mem_bus_active)
      `CHK("oe1", 8'h8F, oe1)
      `CHK("out1", 8'hB, out1 & 8'h0F)
      `CHK("dir2", 8'hFF, dir2)
      // each strobe on its own pin, lcd owning pin 7
      for (int i = 0; i < 8; i++) begin
         mc = mem_ctrl_t'(8'h01 << i);
         step(1);
         `CHK("oe2", 8'hFF, oe2)
         `CHK("out2", (8'h01 << i) & 8'h7F, out2)
      end
      lcd_s1 = 8'h00;
      lcd_s2 = 8'h00;
      mem_addr_used = 1'b0;
      wr(MEM, 8'h80);
      `CHK("bus", 1'b0, mem_bus_active)
      `CHK("oe2", 8'h00, oe2)
      `CHK("oe1", 8'h00, oe1)
      // pull-ups: common enable, then off on output pins
      wr(SLAT, 8'h50);
      wr(PAD, 8'h04);
      `CHK("pu2", 8'hFF, pu2)
      wr(SDIR, 8'h0F);
      step(3);
      `CHK("pu2", 8'h0F, pu2)
      `CHK("oe2", 8'hF0, oe2)
      `CHK("rd2", 8'h5F, rd2)
      wr(SPRT, 8'hA0);
      `CHK("lat2", 8'hA0, lat2)
      `CHK("out2", 8'hA0, out2 & 8'hF0)
      wr(PAD, 8'h00);
      `CHK("pu2", 8'h00, pu2)
      // second reset in mid-run with pull-ups enabled
      wr(PAD, 8'h04);
      rst = 1'b1;
      step(2);
      rst = 1'b0;
      step(2);
      chk_reset();
      give_verdict();
   end
endmodule : testbench
